//--- verilog/tcc_pkg.sv
// Constants, register map and shared helpers of the eight-channel capture/compare timer.
// Assumes a single 10 MHz clock and an APB register bus with 32-bit data.
`default_nettype none
package tcc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NCH    = 8;

	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CHCFG  = 8'h04;
	localparam logic [7:0] OFS_OUTCFG = 8'h08;
	localparam logic [7:0] OFS_FORCE  = 8'h0C;
	localparam logic [7:0] OFS_FLAGS  = 8'h10;
	localparam logic [7:0] OFS_COUNT  = 8'h14;
	localparam logic [7:0] OFS_ACCUM  = 8'h18;
	localparam logic [7:0] OFS_PORT   = 8'h1C;
	localparam logic [2:0] OFS_CHAN_HI = 3'h1;

	localparam int B_RUN  = 0;
	localparam int B_AEN  = 1;
	localparam int B_GATE = 2;
	localparam int B_POL  = 3;
	localparam int B_COUNTER_RESET_ON_MATCH = 4;
	localparam int B_FINE = 5;
	localparam int B_AWIE = 6;
	localparam int B_AGIE = 7;
	localparam int B_CWIE = 8;
	localparam int B_SEL  = 12;
	localparam int B_FVAL = 16;
	localparam int B_CWF  = 8;
	localparam int B_AWF  = 9;
	localparam int B_AGF  = 10;
	localparam int NFLAG  = 11;

	localparam logic [31:0] CTRL_WMASK = 32'h00FF_71FF;
	localparam logic [31:0] PORT_WMASK = 32'h00FF_FFFF;
	localparam logic [31:0] RST_REG32  = 32'h0000_0000;
	localparam logic [15:0] RST_REG16  = 16'h0000;
	localparam logic [15:0] MAX16      = 16'hFFFF;
	localparam logic [5:0]  DIV64_LAST = 6'h3F;

	typedef enum logic [1:0] {
		ACT_NONE   = 2'b00,
		ACT_TOGGLE = 2'b01,
		ACT_CLEAR  = 2'b10,
		ACT_SET    = 2'b11
	} tcc_act_e;

	// New pin state for a compare action applied to the current state.
	function automatic logic tcc_oc_apply(input logic [1:0] act, input logic cur);
		case (tcc_act_e'(act))
			ACT_TOGGLE: tcc_oc_apply = ~cur;
			ACT_CLEAR:  tcc_oc_apply = 1'b0;
			ACT_SET:    tcc_oc_apply = 1'b1;
			default:    tcc_oc_apply = cur;
		endcase
	endfunction
endpackage
`default_nettype wire

//--- verilog/tcc_tick_if.sv
// Carrier between the timer core and its prescaler: configuration one way, tick pulses back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tcc_tick_if;
	logic       run;
	logic       fine;
	logic [2:0] sel;
	logic [7:0] fval;
	logic       tick;
	logic       div64;
	modport pre  (input run, fine, sel, fval, output tick, div64);
	modport core (output run, fine, sel, fval, input tick, div64);
endinterface
`default_nettype wire

//--- verilog/tcc_prescaler.sv
// Timer prescaler: counter tick enable and the divide-by-64 enable for gated accumulation.
// Assumes configuration comes from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tcc_prescaler
	import tcc_pkg::*;
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Core side.
	tcc_tick_if.pre   tk
);
	logic [7:0] cnt_r;
	logic [7:0] last_r;
	logic [7:0] last_nxt;
	logic [5:0] d64_r;

	always_comb begin
		if (tk.fine) begin
			last_nxt = tk.fval;
		end else begin
			last_nxt = 8'((9'h001 << tk.sel) - 9'h001);
		end
	end

	// A new factor is taken while stopped or when the stage counter returns to zero.
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r  <= 8'h00;
			last_r <= 8'h00;
		end else if (!tk.run) begin
			cnt_r  <= 8'h00;
			last_r <= last_nxt;
		end else if (cnt_r == last_r) begin
			cnt_r  <= 8'h00;
			last_r <= last_nxt;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !tk.run) begin
			d64_r <= 6'h00;
		end else begin
			d64_r <= d64_r + 6'h01;
		end
	end

	assign tk.tick  = tk.run && (cnt_r == last_r);
	assign tk.div64 = tk.run && (d64_r == DIV64_LAST);
endmodule
`default_nettype wire

//--- verilog/tcc_timer.sv
// Eight-channel capture/compare timer with pulse accumulator on channel 7, APB slave.
// Assumes timer pins arrive asynchronously and the APB master runs on CORE_CLK.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer
	import tcc_pkg::*;
(
	// Clock and reset.
	input  wire logic                      CORE_CLK,
	input  wire logic                      RESET,
	// APB slave.
	input  wire logic                      PSEL,
	input  wire logic                      PENABLE,
	input  wire logic                      PWRITE,
	input  wire logic [tcc_pkg::ADDR_W-1:0] PADDR,
	input  wire logic [tcc_pkg::DATA_W-1:0] PWDATA,
	output logic      [tcc_pkg::DATA_W-1:0] PRDATA,
	output logic                           PREADY,
	output logic                           PSLVERR,
	// Timer pins.
	input  wire logic [tcc_pkg::NCH-1:0]    TMR_PIN_IN,
	output logic      [tcc_pkg::NCH-1:0]    TMR_PIN_OUT,
	output logic      [tcc_pkg::NCH-1:0]    TMR_PIN_OE_N,
	// Interrupt requests.
	output logic      [tcc_pkg::NCH-1:0]    IRQ_CHANNEL,
	output logic                           IRQ_ACCUM_INPUT,
	output logic                           IRQ_ACCUM_WRAP,
	output logic                           IRQ_COUNTER_WRAP
);
	import tcc_pkg::*;

	// Software registers.
	logic [31:0]      ctrl_r;
	logic [31:0]      chcfg_r;
	logic [31:0]      outcfg_r;
	logic [31:0]      port_r;
	logic [NFLAG-1:0] flags_r;
	logic [15:0]      cnt_r;
	logic [15:0]      acc_r;
	logic [15:0]      chan_r [NCH];
	logic [7:0]       oc_r;
	logic [7:0]       oc_nxt;

	// Pin synchroniser.
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [7:0] sync3_r;
	logic [7:0] lvl_r;
	logic [7:0] chg;
	logic [7:0] rise;
	logic [7:0] fall;

	// Field views.
	logic        run;
	logic        aen;
	logic [7:0]  ios;
	logic [7:0]  ien;
	logic [7:0]  ocpd;
	logic [7:0]  mask7;
	logic [7:0]  overflow_toggle;
	logic [7:0]  data7;
	logic [7:0]  cap_fall;

	// Event terms.
	logic [7:0]  match;
	logic [7:0]  cap;
	logic [7:0]  frc;
	logic [7:0]  mode_nz;
	logic [7:0]  drive_t;
	logic        ovf;
	logic        ev7;
	logic        acc_edge;
	logic        acc_active;
	logic        acc_inc;
	logic        acc_gate_end;
	logic [NFLAG-1:0] fset;
	logic [NFLAG-1:0] fclr;

	// Bus decode.
	logic        acc_ph;
	logic        wr;
	logic        chan_hit;
	logic [2:0]  chan_idx;
	logic [31:0] rd_nxt;
	logic        err_nxt;

	tcc_tick_if tk ();

	assign run      = ctrl_r[B_RUN];
	assign aen      = ctrl_r[B_AEN];
	assign ios      = chcfg_r[7:0];
	assign ien      = chcfg_r[15:8];
	assign ocpd     = chcfg_r[23:16];
	assign mask7    = chcfg_r[31:24];
	assign overflow_toggle     = outcfg_r[23:16];
	assign data7    = outcfg_r[31:24];
	assign cap_fall = port_r[23:16];

	assign tk.run  = run;
	assign tk.fine = ctrl_r[B_FINE];
	assign tk.sel  = ctrl_r[B_SEL +: 3];
	assign tk.fval = ctrl_r[B_FVAL +: 8];

	tcc_prescaler u_pre (
		.clk (CORE_CLK),
		.rst (RESET),
		.tk  (tk.pre)
	);

	// APB: zero wait states, read data captured in the setup cycle.
	assign PREADY   = 1'b1;
	assign acc_ph   = PSEL && PENABLE;
	assign wr       = acc_ph && PWRITE && !err_nxt;
	assign chan_hit = (PADDR[7:5] == OFS_CHAN_HI) && (PADDR[1:0] == 2'b00);
	assign chan_idx = PADDR[4:2];

	always_comb begin
		rd_nxt  = RST_REG32;
		err_nxt = 1'b0;
		if (chan_hit) begin
			rd_nxt = {16'h0000, chan_r[chan_idx]};
		end else begin
			case (PADDR)
				OFS_CTRL:   rd_nxt = ctrl_r;
				OFS_CHCFG:  rd_nxt = chcfg_r;
				OFS_OUTCFG: rd_nxt = outcfg_r;
				OFS_FORCE:  rd_nxt = RST_REG32;
				OFS_FLAGS:  rd_nxt = {21'h000000, flags_r};
				OFS_COUNT:  rd_nxt = {16'h0000, cnt_r};
				OFS_ACCUM:  rd_nxt = {16'h0000, acc_r};
				OFS_PORT:   rd_nxt = {lvl_r, port_r[23:0]};
				default:    err_nxt = 1'b1;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			PRDATA  <= RST_REG32;
			PSLVERR <= 1'b0;
		end else if (PSEL && !PENABLE) begin
			PRDATA  <= PWRITE ? RST_REG32 : rd_nxt;
			PSLVERR <= err_nxt;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			ctrl_r   <= RST_REG32;
			chcfg_r  <= RST_REG32;
			outcfg_r <= RST_REG32;
			port_r   <= RST_REG32;
		end else if (wr) begin
			case (PADDR)
				OFS_CTRL:   ctrl_r   <= PWDATA & CTRL_WMASK;
				OFS_CHCFG:  chcfg_r  <= PWDATA;
				OFS_OUTCFG: outcfg_r <= PWDATA;
				OFS_PORT:   port_r   <= PWDATA & PORT_WMASK;
				default:    ;
			endcase
		end
	end

	// A level counts once the second and third stages agree.
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
			sync3_r <= 8'h00;
			lvl_r   <= 8'h00;
		end else begin
			sync1_r <= TMR_PIN_IN;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			lvl_r   <= lvl_r ^ chg;
		end
	end

	assign chg  = ~(sync2_r ^ sync3_r) & (sync2_r ^ lvl_r);
	assign rise = chg & sync2_r;
	assign fall = chg & ~sync2_r;

	// Compare and capture events.
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			match[i]   = run && tk.tick && (cnt_r == chan_r[i]);
			mode_nz[i] = |outcfg_r[2*i +: 2];
		end
	end

	assign cap = ~ios & ((rise & ~cap_fall) | (fall & cap_fall));
	assign ovf = run && tk.tick && (cnt_r == MAX16);
	assign ev7 = (match[7] && ios[7]) || (ovf && overflow_toggle[7]);
	assign frc = (wr && (PADDR == OFS_FORCE)) ? (PWDATA[7:0] & ios) : 8'h00;

	// Free-running counter.
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			cnt_r <= RST_REG16;
		end else if (run && tk.tick) begin
			if (ctrl_r[B_COUNTER_RESET_ON_MATCH] && match[7] && (chan_r[7] != RST_REG16)) begin
				cnt_r <= RST_REG16;
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end

	// Channel registers: capture wins over a software write in the same cycle.
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			for (int i = 0; i < NCH; i++) begin
				chan_r[i] <= RST_REG16;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (cap[i]) begin
					chan_r[i] <= cnt_r;
				end else if (wr && chan_hit && (chan_idx == 3'(i))) begin
					chan_r[i] <= PWDATA[15:0];
				end
			end
		end
	end

	// Output register: per-channel action first, then the channel 7 override on masked pins.
	always_comb begin
		oc_nxt = oc_r;
		for (int i = 0; i < NCH; i++) begin
			if (ios[i] && (match[i] || frc[i])) begin
				oc_nxt[i] = tcc_oc_apply(outcfg_r[2*i +: 2], oc_r[i]);
			end
		end
		if (ev7 || frc[7]) begin
			oc_nxt = (oc_nxt & ~mask7) | (data7 & mask7);
		end
	end

	// The output register updates even while the pin is disconnected.
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			oc_r <= 8'h00;
		end else begin
			oc_r <= oc_nxt;
		end
	end

	// Timer owns a pin when compare is selected, connected and an action or mask is set.
	assign drive_t = ios & ~ocpd & (mode_nz | mask7);

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			TMR_PIN_OUT  <= 8'h00;
			TMR_PIN_OE_N <= 8'hFF;
		end else begin
			TMR_PIN_OUT  <= (drive_t & oc_r) | (~drive_t & port_r[7:0]);
			TMR_PIN_OE_N <= ~(drive_t | port_r[15:8]);
		end
	end

	// Pulse accumulator on the synchronised channel 7 level.
	assign acc_edge   = ctrl_r[B_POL] ? rise[7] : fall[7];
	assign acc_active = (lvl_r[7] == ctrl_r[B_POL]);

	always_comb begin
		if (ctrl_r[B_GATE]) begin
			acc_inc      = aen && tk.div64 && acc_active;
			acc_gate_end = aen && (ctrl_r[B_POL] ? fall[7] : rise[7]);
		end else begin
			acc_inc      = aen && acc_edge;
			acc_gate_end = aen && acc_edge;
		end
	end

	// A software write to the count wins over a simultaneous increment.
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			acc_r <= RST_REG16;
		end else if (wr && (PADDR == OFS_ACCUM)) begin
			acc_r <= PWDATA[15:0];
		end else if (acc_inc) begin
			acc_r <= acc_r + 16'h0001;
		end
	end

	// Sticky flags: hardware set wins over a write-one clear in the same cycle.
	always_comb begin
		fset        = '0;
		fset[7:0]   = (ios & match) | cap;
		fset[B_CWF] = ovf;
		fset[B_AWF] = acc_inc && (acc_r == MAX16);
		fset[B_AGF] = acc_gate_end;
		fclr        = '0;
		if (wr && (PADDR == OFS_FLAGS) && (run || aen)) begin
			fclr = PWDATA[NFLAG-1:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			flags_r <= '0;
		end else begin
			flags_r <= (flags_r & ~fclr) | fset;
		end
	end

	// Eleven separate active-high requests.
	assign IRQ_CHANNEL      = flags_r[7:0] & ien;
	assign IRQ_COUNTER_WRAP = flags_r[B_CWF] & ctrl_r[B_CWIE];
	assign IRQ_ACCUM_WRAP   = flags_r[B_AWF] & ctrl_r[B_AWIE];
	assign IRQ_ACCUM_INPUT  = flags_r[B_AGF] & ctrl_r[B_AGIE];
endmodule
`default_nettype wire

//--- verification/tcc_pin_model.sv
// Far-side model of the timer pins: an external pulse source per channel.
// Assumes the bench calls pulse() from a process that runs on clk.
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
	// Clock.
	input  wire logic       clk,
	// Timer side.
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe_n,
	output logic      [7:0] pin_in
);
	logic [7:0] ext_r = 8'h00;
	// The wire follows the timer where it drives and the source elsewhere.
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_r & pin_oe_n);
	// Each pulse stays high for at least three clocks.
	task automatic pulse(input int ch, input int width);
		@(posedge clk);
		ext_r[ch] <= 1'b1;
		repeat ((width < 3) ? 3 : width) @(posedge clk);
		ext_r[ch] <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- verification/tcc_timer_monitor.sv
// Checker of the timer's APB, pin and interrupt ports.
// Assumes it is bound to tcc_timer and runs on CORE_CLK.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_monitor
	import tcc_pkg::*;
(
	// Clock and reset.
	input wire logic                        CORE_CLK,
	input wire logic                        RESET,
	// APB.
	input wire logic                        PSEL,
	input wire logic                        PENABLE,
	input wire logic                        PWRITE,
	input wire logic [tcc_pkg::ADDR_W-1:0]  PADDR,
	input wire logic [tcc_pkg::DATA_W-1:0]  PRDATA,
	input wire logic                        PREADY,
	input wire logic                        PSLVERR,
	// Pins and requests.
	input wire logic [tcc_pkg::NCH-1:0]     TMR_PIN_OUT,
	input wire logic [tcc_pkg::NCH-1:0]     TMR_PIN_OE_N,
	input wire logic [tcc_pkg::NCH-1:0]     IRQ_CHANNEL,
	input wire logic                        IRQ_ACCUM_INPUT,
	input wire logic                        IRQ_ACCUM_WRAP,
	input wire logic                        IRQ_COUNTER_WRAP
);
	logic [7:0] addr_r;
	logic [7:0] irq_r;
	logic       wr_r;
	always_ff @(posedge CORE_CLK) begin
		addr_r <= PADDR;
		irq_r <= IRQ_CHANNEL;
		wr_r <= PSEL && PENABLE && PWRITE;
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_access;
		s_setup ##1 (PSEL && PENABLE);
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0) RESET |=> IRQ_CHANNEL == 8'h00
		&& !IRQ_ACCUM_INPUT && !IRQ_ACCUM_WRAP && !IRQ_COUNTER_WRAP
		&& TMR_PIN_OE_N == 8'hFF && TMR_PIN_OUT == 8'h00) else $error("reset state wrong");
	a_ready_zero_wait: assert property (s_access |-> PREADY) else $error("wait state seen");
	a_slverr_decode: assert property (s_setup |=> PSLVERR == (addr_r > 8'h3C
		|| addr_r[1:0] != 2'b00)) else $error("error response wrong");
	a_error_reads_zero: assert property (s_access ##0 (!PWRITE && PSLVERR) |-> PRDATA == 32'h0)
		else $error("error read not zero");
	a_write_reads_zero: assert property (s_setup ##0 PWRITE |=> PRDATA == 32'h0)
		else $error("write returned data");
	a_force_reads_zero: assert property (s_setup ##0 (!PWRITE && PADDR == OFS_FORCE)
		|=> PRDATA == 32'h0) else $error("force register readable");
	a_irq_fall_cause: assert property (|(irq_r & ~IRQ_CHANNEL) |-> wr_r)
		else $error("channel request dropped without write");
	a_wrap_irq_fall: assert property ($fell(IRQ_COUNTER_WRAP) || $fell(IRQ_ACCUM_WRAP)
		|| $fell(IRQ_ACCUM_INPUT) |-> wr_r) else $error("request dropped without write");
	a_drive_from_config: assert property (!$stable(TMR_PIN_OE_N) |-> wr_r || $past(wr_r))
		else $error("pin drive changed without write");
endmodule
bind tcc_timer tcc_timer_monitor u_mon (.CORE_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.PRDATA, .PREADY, .PSLVERR, .TMR_PIN_OUT, .TMR_PIN_OE_N, .IRQ_CHANNEL, .IRQ_ACCUM_INPUT,
	.IRQ_ACCUM_WRAP, .IRQ_COUNTER_WRAP);
`default_nettype wire

//--- verification/tcc_timer_tb.sv
// Self-checking bench of tcc_timer: APB master, pin model and queued read checks.
// Assumes tcc_pin_model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_tb;
	import tcc_pkg::*;
	typedef struct {logic [31:0] d; logic [31:0] m;} tcc_exp_s;
	tcc_exp_s    exp_q[$];
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, iai, iaw, icw;
	logic [7:0]  pin_in, pin_out, oe_n, irq_ch;
	int          bad_count = 0;
	int          compares = 0;
	int          n, p, f, ch, seed;
	always #50 clk = ~clk;
	tcc_timer DUT (.CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TMR_PIN_IN(pin_in), .TMR_PIN_OUT(pin_out), .TMR_PIN_OE_N(oe_n), .IRQ_CHANNEL(irq_ch),
		.IRQ_ACCUM_INPUT(iai), .IRQ_ACCUM_WRAP(iaw), .IRQ_COUNTER_WRAP(icw));
	tcc_pin_model pm (.clk(clk), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_in(pin_in));
	task automatic cmp(input logic [31:0] got, input logic [31:0] want);
		compares++;
		if (got !== want) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask
	// Pin and request levels are looked at half a clock after they settle.
	task automatic cmp_lvl(input logic [31:0] got, input logic [31:0] want);
		compares++;
		if (got !== want) begin
			bad_count++;
			$display("BAD %0t level %h want %h", $time, got, want);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic settle;
		cyc(2);
		@(negedge clk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		exp_q.push_back('{d, m});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic do_reset;
		@(posedge clk);
		rst <= 1'b1;
		cyc(8);
		rst <= 1'b0;
	endtask
	task automatic complete_run;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Read results are checked in completion order against the queued notes.
	always @(posedge clk) begin
		if (psel && pen && !pwr && pready === 1'b1 && exp_q.size() > 0) begin
			cmp(prdata & exp_q[0].m, exp_q[0].d & exp_q[0].m);
			void'(exp_q.pop_front());
		end
	end
	initial begin
		cyc(60000);
		bad_count++;
		complete_run();
	end
	initial begin
		seed = $urandom(17188);
		do_reset();
		for (int i = 0; i < 18; i++) rd(8'(4 * i), 32'h0, 32'hFFFF_FFFF);
		rd(8'h41, 32'h0, 32'hFFFF_FFFF);
		ch = $urandom % 7;
		wr(8'h20 + 8'(4 * ch), 32'(1 + $urandom % 16'hFFFE));
		wr(OFS_CHCFG, 32'h100 << ch);
		pm.pulse(ch, 3);
		cyc(6);
		rd(8'h20 + 8'(4 * ch), 32'h0, 32'hFFFF);
		rd(OFS_FLAGS, 32'h1 << ch, 32'hFFFF_FFFF);
		settle();
		cmp_lvl(32'(irq_ch), 32'h1 << ch);
		wr(OFS_FLAGS, 32'h1 << ch);
		rd(OFS_FLAGS, 32'h1 << ch, 32'hFFFF_FFFF);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_FLAGS, 32'h1 << ch);
		settle();
		cmp_lvl(32'(irq_ch), 32'h0);
		// Accumulator counts channel 7 edges in edge mode, for each polarity.
		for (int pol = 0; pol < 2; pol++) begin
			n = 1 + $urandom % 5;
			wr(OFS_CTRL, 32'h42 | (32'(pol) << B_POL));
			wr(OFS_ACCUM, 32'h0);
			repeat (n) begin
				pm.pulse(7, 3);
				cyc(3);
			end
			cyc(5);
			rd(OFS_ACCUM, 32'(n), 32'hFFFF_FFFF);
		end
		wr(OFS_ACCUM, 32'hFFFF);
		pm.pulse(7, 3);
		cyc(6);
		rd(OFS_ACCUM, 32'h0, 32'hFFFF_FFFF);
		settle();
		cmp_lvl(32'(iaw), 32'h1);
		wr(OFS_FLAGS, 32'h200);
		settle();
		cmp_lvl(32'(iaw), 32'h0);
		wr(OFS_ACCUM, 32'h0);
		wr(OFS_CTRL, 32'h8E);
		pm.pulse(7, 300);
		cyc(6);
		rd(OFS_ACCUM, 32'h0, 32'hFFFF_FFFF);
		wr(OFS_FLAGS, 32'h700);
		wr(OFS_CTRL, 32'h8F);
		pm.pulse(7, 288);
		cyc(6);
		rd(OFS_ACCUM, 32'h4, 32'hFFFE);
		settle();
		cmp_lvl(32'(iai), 32'h1);
		do_reset();
		for (int i = 0; i < 5; i++) wr(8'h20 + 8'(4 * i), 32'h40);
		wr(8'h3C, 32'h50);
		wr(OFS_OUTCFG, 32'h0200_0139);
		wr(OFS_CHCFG, 32'h0210_009F);
		wr(OFS_CTRL, 32'h1);
		cyc(120);
		settle();
		cmp_lvl(32'(pin_out[2:0]), 32'h7);
		cmp_lvl(32'(oe_n[4:0]), 32'h18);
		rd(OFS_FLAGS, 32'h9F, 32'h9F);
		wr(OFS_PORT, 32'h100);
		settle();
		cmp_lvl(32'(pin_out[0]), 32'h1);
		wr(OFS_FLAGS, 32'hFF);
		wr(OFS_FORCE, 32'h1);
		settle();
		cmp_lvl(32'(pin_out[0]), 32'h0);
		rd(OFS_FLAGS, 32'h0, 32'h1);
		wr(OFS_OUTCFG, 32'h0200_0D39);
		wr(OFS_CHCFG, 32'h0230_00BF);
		wr(OFS_FORCE, 32'h20);
		settle();
		cmp_lvl(32'(oe_n[5]), 32'h1);
		wr(OFS_CHCFG, 32'h0210_00BF);
		settle();
		cmp_lvl(32'({oe_n[5], pin_out[5]}), 32'h1);
		do_reset();
		wr(8'h3C, 32'h7);
		wr(OFS_CTRL, 32'h13);
		repeat (8) begin
			cyc($urandom % 9);
			rd(OFS_COUNT, 32'h0, 32'hFFF8);
		end
		f = 8 + $urandom % 32;
		for (int i = 0; i < 6; i++) begin
			p = (i < 5) ? (8 << i) : f + 1;
			do_reset();
			wr(OFS_CTRL, (i < 5) ? ((32'(i + 3) << B_SEL) | 32'h1) : ((32'(f) << B_FVAL) | 32'h21));
			cyc(p * 17 / 2);
			rd(OFS_COUNT, 32'h8, 32'hFFFE);
		end
		cyc(4);
		complete_run();
	end
endmodule
`default_nettype wire
